// >>> baud_tick_gen.sv
// Baud prescaler: one-cycle tick every divisor plus one clock cycles
module baud_tick_gen #(
  parameter int WIDTH = spim_pkg::DIV_WIDTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic reload_i,
  input wire logic [WIDTH-1:0] divisor_i,
  // Half-period strobe
  output logic tick_o
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  wire logic at_zero_w = (count_r == '0);

  // Held at the divisor while stopped, so the first half period is full length
  assign tick_o = run_i && !reload_i && at_zero_w;
  assign count_nxt = (!run_i || reload_i || at_zero_w) ? divisor_i : count_r - 1'b1;

  // Counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule // baud_tick_gen

// >>> spi_slave_model.sv
// Echoing three-wire serial slave that faces the master controller
module spi_slave_model (
  // Link
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Mode mirror and resync
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic clr_i,
  // Observation
  output logic [7:0] got_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int samples = 0;
  int pos = 0;
  logic [7:0] shift_r = 8'h00;
  logic mosi_q = 1'b1;
  initial got_o = 8'hA5;
  initial done_o = 1'b0;
  // Replies with the previous byte, so the first frame carries the A5 start value
  assign miso_o = lsb_i ? got_o[pos[2:0]] : got_o[3'h7 - pos[2:0]];
  // The master may move its data line on the same clock edge as its last
  // sample edge, so the slave samples a copy that lags by a little hold time
  always @(mosi_i) mosi_q <= #1 mosi_i;
  ////////////////////////////////////////
  // Sample on the mode's sample edge, advance on the other
  always @(sck_i) begin
    if ((sck_i != cpol_i) ^ cpha_i) begin
      shift_r = lsb_i ? {mosi_q, shift_r[7:1]} : {shift_r[6:0], mosi_q};
      samples = samples + 1;
      if (samples == 8) begin
        got_o = shift_r;
        samples = 0;
        pos = 0;
        done_o = 1'b1;
        #1 done_o = 1'b0;
      end
    end else begin
      pos = samples;
    end
  end
  // An idle level change looks like an edge, so drop the partial count
  always @(posedge clr_i) begin
    samples = 0;
    pos = 0;
  end
endmodule // spi_slave_model

// >>> spim_master.sv
// Master-only SPI transfer controller with buffered transmit and two-level receive
module spim_master #(
  parameter int DIV_W = spim_pkg::DIV_WIDTH
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // Configuration
  input wire logic [1:0] OPERATING_MODE_SELECT_I,
  input wire logic CLOCK_POLARITY_BIT_I,
  input wire logic CLOCK_PHASE_BIT_I,
  input wire logic BIT_ORDER_SELECT_I,
  input wire logic TRANSMITTER_ENABLE_BIT_I,
  input wire logic RECEIVER_ENABLE_BIT_I,
  input wire logic SHIFT_CLOCK_PIN_DIRECTION_I,
  // Baud divisor write
  input wire logic [DIV_W-1:0] BAUD_DIVISOR_I,
  input wire logic BAUD_DIVISOR_WR_I,
  // Data register access
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_WRITE_I,
  input wire logic RX_READ_I,
  output logic [7:0] RX_DATA_O,
  // Status
  input wire logic TXC_CLEAR_I,
  output logic TRANSMIT_COMPLETE_FLAG_O,
  output logic RECEIVE_COMPLETE_FLAG_O,
  output logic TRANSMIT_BUFFER_EMPTY_FLAG_O,
  output logic FRAME_ERROR_O,
  output logic DATA_OVERRUN_O,
  output logic PARITY_ERROR_O,
  output logic MODE_ACTIVE_O,
  // Pins
  output logic SHIFT_CLOCK_PIN_O,
  output logic SHIFT_CLOCK_PIN_OE_N_O,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE_N_O,
  input wire logic SERIAL_IN_PIN_I,
  output logic SERIAL_IN_OVERRIDE_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Shift one bit in at the end selected by the common order setting
  function automatic logic [7:0] shift_in(input logic [7:0] word, input logic bit_in,
                                          input logic lsb_first);
    shift_in = lsb_first ? {bit_in, word[7:1]} : {word[6:0], bit_in};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  spim_pkg::xfer_state_e state_r;
  spim_pkg::xfer_state_e state_nxt;
  logic [DIV_W-1:0] baud_divisor_r;
  logic txen_eff_r;
  logic txen_eff_nxt;
  logic [7:0] tx_buf_r;
  logic tx_full_r;
  logic tx_full_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] rx_shift_r;
  logic [7:0] rx_shift_nxt;
  logic [3:0] half_r;
  logic [3:0] half_nxt;
  logic sck_r;
  logic sck_nxt;
  logic sout_r;
  logic sout_nxt;
  logic txc_r;
  logic sin_meta_r;
  logic sin_sync_r;
  logic [7:0] rx_buf_r [2];
  logic [1:0] rx_count_r;
  logic [1:0] rx_count_nxt;
  logic tick_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  // Only the master SPI encoding wakes the controller; the other transceiver
  // modes, parity and clock recovery have no logic here at all
  wire logic mode_on_w = (OPERATING_MODE_SELECT_I == spim_pkg::MODE_SPI_MASTER);
  wire logic busy_w = (state_r == spim_pkg::ST_SHIFT);
  wire logic edge_w = tick_w && busy_w;
  // Sample on leading edge for phase 0, trailing for phase 1
  wire logic sample_w = edge_w && (half_r[0] == CLOCK_PHASE_BIT_I);
  // Phase 1 presents its first bit at load, so its first setup edge does not shift
  wire logic setup_w = edge_w && !sample_w && (half_r != 4'h0);
  wire logic last_w = edge_w && (half_r == spim_pkg::HALF_LAST);
  // A byte leaves the buffer as soon as the shifter is idle or just finishing
  wire logic load_w = mode_on_w && txen_eff_r && tx_full_r && (!busy_w || last_w);
  // Writing the data register is the only thing that starts traffic
  wire logic accept_w = TX_WRITE_I && mode_on_w && txen_eff_r && (!tx_full_r || load_w);
  wire logic push_w = last_w && RECEIVER_ENABLE_BIT_I;
  wire logic pop_w = RX_READ_I && (rx_count_r != 2'h0);
  // A full receive buffer refuses the newest byte and keeps what it holds
  wire logic rx_take_w = push_w && ((rx_count_r < spim_pkg::RX_DEPTH) || pop_w);
  wire logic [1:0] fill_w = rx_count_r - {1'b0, pop_w};
  wire logic txc_set_w = last_w && !load_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Baud generator, restarted by a divisor write and stopped between frames

  baud_tick_gen #(
    .WIDTH(DIV_W)
  ) u_baud (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .run_i(busy_w),
    .reload_i(BAUD_DIVISOR_WR_I),
    .divisor_i(baud_divisor_r),
    .tick_o(tick_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state selection

  // Leaving the mode drops the frame; changing polarity mid-frame is not guarded
  assign state_nxt = !mode_on_w ? spim_pkg::ST_IDLE :
                     load_w ? spim_pkg::ST_SHIFT :
                     last_w ? spim_pkg::ST_IDLE : state_r;
  assign half_nxt = load_w ? 4'h0 : edge_w ? half_r + 4'h1 : half_r;
  // Clock rests at polarity level outside frames; a gapless load keeps it there
  assign sck_nxt = (state_nxt == spim_pkg::ST_IDLE || load_w) ? CLOCK_POLARITY_BIT_I :
                   edge_w ? !sck_r : sck_r;
  assign shift_nxt = load_w ? tx_buf_r :
                     setup_w ? shift_in(shift_r, spim_pkg::LINE_IDLE, BIT_ORDER_SELECT_I) :
                     shift_r;
  assign sout_nxt = (state_nxt == spim_pkg::ST_SHIFT) ?
                    (BIT_ORDER_SELECT_I ? shift_nxt[0] : shift_nxt[7]) :
                    spim_pkg::LINE_IDLE;
  assign rx_shift_nxt = sample_w ? shift_in(rx_shift_r, sin_sync_r, BIT_ORDER_SELECT_I) :
                        rx_shift_r;
  assign tx_full_nxt = !mode_on_w ? 1'b0 : accept_w ? 1'b1 : load_w ? 1'b0 : tx_full_r;
  // A disable only lands once nothing is left to send
  assign txen_eff_nxt = TRANSMITTER_ENABLE_BIT_I ? 1'b1 :
                        (!busy_w && !tx_full_r) ? 1'b0 : txen_eff_r;
  // Dropping the receiver enable flushes the buffer
  assign rx_count_nxt = !RECEIVER_ENABLE_BIT_I ? 2'h0 : fill_w + {1'b0, rx_take_w};

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer registers

  // Controller state and pin shadows
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      state_r <= spim_pkg::ST_IDLE;
      half_r <= 4'h0;
      sck_r <= 1'b0;
      sout_r <= spim_pkg::LINE_IDLE;
      shift_r <= 8'h00;
      rx_shift_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      half_r <= half_nxt;
      sck_r <= sck_nxt;
      sout_r <= sout_nxt;
      shift_r <= shift_nxt;
      rx_shift_r <= rx_shift_nxt;
    end
  end

  // Divisor resets to zero, so half periods last one cycle until a divisor write
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      baud_divisor_r <= spim_pkg::DIV_RESET;
    end else if (BAUD_DIVISOR_WR_I) begin
      baud_divisor_r <= BAUD_DIVISOR_I;
    end
  end

  // Transmit buffer and enables
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      tx_buf_r <= 8'h00;
      tx_full_r <= !spim_pkg::TBE_RESET;
      txen_eff_r <= 1'b0;
    end else begin
      tx_full_r <= tx_full_nxt;
      txen_eff_r <= txen_eff_nxt;
      if (accept_w) begin
        tx_buf_r <= TX_DATA_I;
      end
    end
  end

  // Completion flag: a set in the clearing cycle wins
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      txc_r <= spim_pkg::TXC_RESET;
    end else if (txc_set_w) begin
      txc_r <= 1'b1;
    end else if (TXC_CLEAR_I) begin
      txc_r <= 1'b0;
    end
  end

  // Input pin synchroniser
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      sin_meta_r <= 1'b1;
      sin_sync_r <= 1'b1;
    end else begin
      sin_meta_r <= SERIAL_IN_PIN_I;
      sin_sync_r <= sin_meta_r;
    end
  end

  // Two-level receive buffer, oldest at index 0
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rx_count_r <= 2'h0;
      rx_buf_r[0] <= 8'h00;
      rx_buf_r[1] <= 8'h00;
    end else begin
      rx_count_r <= rx_count_nxt;
      if (pop_w) begin
        rx_buf_r[0] <= rx_buf_r[1];
      end
      if (rx_take_w) begin
        rx_buf_r[fill_w[0]] <= rx_shift_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Flags behave as in the plain transceiver; error flags have no source here
  assign TRANSMIT_COMPLETE_FLAG_O = txc_r;
  assign RECEIVE_COMPLETE_FLAG_O = (rx_count_r != 2'h0);
  assign TRANSMIT_BUFFER_EMPTY_FLAG_O = !tx_full_r;
  assign FRAME_ERROR_O = 1'b0;
  assign DATA_OVERRUN_O = 1'b0;
  assign PARITY_ERROR_O = 1'b0;
  assign MODE_ACTIVE_O = mode_on_w;
  assign RX_DATA_O = rx_buf_r[0];
  // Clock pin follows its direction setting whether or not the receiver is on
  assign SHIFT_CLOCK_PIN_O = sck_r;
  assign SHIFT_CLOCK_PIN_OE_N_O = !SHIFT_CLOCK_PIN_DIRECTION_I;
  assign SERIAL_OUT_PIN_O = sout_r;
  assign SERIAL_OUT_PIN_OE_N_O = !txen_eff_r;
  assign SERIAL_IN_OVERRIDE_O = RECEIVER_ENABLE_BIT_I;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Cycles since the previous half-period tick, counted from frame load
  logic [DIV_W:0] tick_gap_r;
  // Sample edges seen in the current frame
  logic [3:0] samples_r;
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I || load_w || tick_w) begin
      tick_gap_r <= {{DIV_W{1'b0}}, 1'b1};
    end else begin
      tick_gap_r <= tick_gap_r + {{DIV_W{1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I || load_w) begin
      samples_r <= 4'h0;
    end else if (sample_w) begin
      samples_r <= samples_r + 4'h1;
    end
  end

  sequence frame_end_s;
    last_w && !load_w;
  endsequence

  sequence idle_return_s;
    state_r == spim_pkg::ST_IDLE && sout_r == spim_pkg::LINE_IDLE
      && sck_r == $past(CLOCK_POLARITY_BIT_I);
  endsequence

  mode_gate_a: assert property (!mode_on_w |=> !busy_w && !tx_full_r)
    else $error("controller active outside master SPI mode");

  half_period_a: assert property (edge_w && $stable(baud_divisor_r)
      |-> tick_gap_r == {1'b0, baud_divisor_r} + {{DIV_W{1'b0}}, 1'b1})
    else $error("half period differs from divisor plus one");

  // A gapless load may land on the last sample edge of a phase 1 frame
  setup_hold_a: assert property (sample_w && !load_w |=> shift_r == $past(shift_r))
    else $error("output changed on a sample edge");

  frame_bits_a: assert property (last_w |-> samples_r + {3'h0, sample_w}
      == spim_pkg::FRAME_SAMPLES)
    else $error("frame did not sample eight bits");

  idle_line_a: assert property (frame_end_s |=> idle_return_s)
    else $error("line or clock not idle after last frame");

  gapless_a: assert property (last_w && load_w |=> busy_w && half_r == 4'h0 && !txc_r
      ##1 busy_w)
    else $error("queued frame not started without gap");

  txc_set_a: assert property (frame_end_s |=> TRANSMIT_COMPLETE_FLAG_O)
    else $error("transmit complete not raised");

  overflow_keep_a: assert property (push_w && rx_count_r == spim_pkg::RX_DEPTH
      && !pop_w && RECEIVER_ENABLE_BIT_I |=> rx_buf_r[1] == $past(rx_buf_r[1])
      && rx_count_r == spim_pkg::RX_DEPTH)
    else $error("receive overflow replaced an older byte");

  disable_wait_a: assert property (!TRANSMITTER_ENABLE_BIT_I && txen_eff_r
      && (busy_w || tx_full_r) |=> txen_eff_r)
    else $error("transmitter released with data pending");

  tbe_reset_a: assert property ($rose(RST_N_I) |-> TRANSMIT_BUFFER_EMPTY_FLAG_O
      && !TRANSMIT_COMPLETE_FLAG_O)
    else $error("transmit buffer not empty after reset");

  div_reset_a: assert property ($rose(RST_N_I) |-> baud_divisor_r == spim_pkg::DIV_RESET)
    else $error("divisor not zero after reset");

  write_start_a: assert property (!busy_w && !tx_full_r && !TX_WRITE_I |=> !busy_w)
    else $error("transfer started without a data write");

endmodule // spim_master

// >>> spim_pkg.sv
// Constants and types of the master-only serial peripheral mode
package spim_pkg;
  localparam logic [1:0] MODE_SPI_MASTER = 2'h3;
  localparam int DIV_WIDTH = 12;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [3:0] HALF_LAST = 4'hF;
  localparam logic [3:0] FRAME_SAMPLES = 4'h8;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  localparam logic TBE_RESET = 1'b1;
  localparam logic TXC_RESET = 1'b0;
  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_e;
endpackage

// >>> usart_master_spi_mode_test.sv
// Self-checking bench for the master serial peripheral mode controller
module usart_master_spi_mode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n, pol, pha, lsb, txen, rxen, dir, dwr, txw, rrd, tcl, clr;
  logic [1:0] mode;
  logic [11:0] dv;
  logic [7:0] txd, rxd, got;
  logic txc, rxc, tbe, fe, dor, pe, mact, sck, sck_oe_n, sout, sout_oe_n, sinov, miso, done;
  logic sck_q = 1'b0;
  logic [7:0] exp_tx[$];
  logic [7:0] exp_rx[$];
  logic [7:0] last = 8'hA5;
  int err_count = 0;
  int checks_done = 0;
  int seed = 9;
  int tog = 0;
  int gap = 0;
  int div = 0;
  int frames = 0;
  int fmark = 0;
  int k;
  always #5 clk = ~clk;
  spim_master dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .OPERATING_MODE_SELECT_I(mode),
    .CLOCK_POLARITY_BIT_I(pol), .CLOCK_PHASE_BIT_I(pha), .BIT_ORDER_SELECT_I(lsb),
    .TRANSMITTER_ENABLE_BIT_I(txen), .RECEIVER_ENABLE_BIT_I(rxen),
    .SHIFT_CLOCK_PIN_DIRECTION_I(dir), .BAUD_DIVISOR_I(dv), .BAUD_DIVISOR_WR_I(dwr),
    .TX_DATA_I(txd), .TX_WRITE_I(txw), .RX_READ_I(rrd), .RX_DATA_O(rxd), .TXC_CLEAR_I(tcl),
    .TRANSMIT_COMPLETE_FLAG_O(txc), .RECEIVE_COMPLETE_FLAG_O(rxc),
    .TRANSMIT_BUFFER_EMPTY_FLAG_O(tbe), .FRAME_ERROR_O(fe), .DATA_OVERRUN_O(dor),
    .PARITY_ERROR_O(pe), .MODE_ACTIVE_O(mact), .SHIFT_CLOCK_PIN_O(sck),
    .SHIFT_CLOCK_PIN_OE_N_O(sck_oe_n), .SERIAL_OUT_PIN_O(sout),
    .SERIAL_OUT_PIN_OE_N_O(sout_oe_n), .SERIAL_IN_PIN_I(miso), .SERIAL_IN_OVERRIDE_O(sinov));
  spi_slave_model slave (.sck_i(sck), .mosi_i(sout), .miso_o(miso), .cpol_i(pol),
    .cpha_i(pha), .lsb_i(lsb), .clr_i(clr), .got_o(got), .done_o(done));
  ////////////////////////////////////////
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp_byte({7'h00, g}, {7'h00, e});
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_sig(input int sel);
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk);
      if ((sel == 0 && tbe === 1'b1) || (sel == 1 && txc === 1'b1)) return;
      if ((sel == 2 && rxc === 1'b1) || (sel == 3 && frames == fmark)) return;
    end
    cmp_flag(1'b0, 1'b1);
    report_and_stop();
  endtask
  task automatic poke(input logic [7:0] d);
    @(posedge clk);
    txd <= d;
    txw <= 1'b1;
    @(posedge clk);
    txw <= 1'b0;
  endtask
  // Queue the bytes the slave and the receive buffer should show
  task automatic send(input logic [7:0] d, input logic keep);
    wait_sig(0);
    poke(d);
    exp_tx.push_back(d);
    if (keep) exp_rx.push_back(last);
    last = d;
  endtask
  task automatic rd();
    wait_sig(2);
    @(posedge clk);
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
  endtask
  task automatic clr_txc();
    @(posedge clk);
    tcl <= 1'b1;
    @(posedge clk);
    tcl <= 1'b0;
    @(negedge clk);
    cmp_flag(txc, 1'b0);
  endtask
  task automatic set_div(input int d);
    @(posedge clk);
    dv <= 12'(d);
    dwr <= 1'b1;
    div = d;
    @(posedge clk);
    dwr <= 1'b0;
  endtask
  // Idle clock level may flip here, so the slave and gap monitor resync
  task automatic cfg(input logic [1:0] m, input logic [2:0] f, input logic t, input logic r);
    @(posedge clk);
    mode <= m;
    {pol, pha, lsb} <= f;
    txen <= t;
    rxen <= r;
    repeat (3) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////
  // Watchers: slave frames, register reads and half periods of the clock
  always @(posedge done) begin
    frames++;
    cmp_byte(got, exp_tx.size() ? exp_tx.pop_front() : 8'hXX);
  end
  always @(negedge clk)
    if (rrd && rxc === 1'b1) cmp_byte(rxd, exp_rx.size() ? exp_rx.pop_front() : 8'hXX);
  always @(posedge clk) begin
    sck_q <= sck;
    if (clr) tog <= 0;
    else if (sck !== sck_q) begin
      if (tog != 0) cmp_byte(8'(gap), 8'(div + 1));
      tog <= (tog == 15) ? 0 : tog + 1;
      gap <= 1;
    end else gap <= gap + 1;
  end
  initial begin
    rst_n = 1'b0;
    {mode, pol, pha, lsb, txen, rxen, dwr, txw, rrd, tcl, clr} = 12'h000;
    dir = 1'b1;
    dv = 12'h000;
    txd = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp_flag(tbe, 1'b1);
    cmp_flag(txc | rxc | sout_oe_n === 1'b0, 1'b0);
    cmp_flag(fe | dor | pe, 1'b0);
    cmp_flag(sout, 1'b1);
    cmp_flag(mact, 1'b0);
    // Divisor left at reset: half periods of one cycle, receiver off
    cfg(2'h3, 3'h0, 1'b1, 1'b0);
    cmp_flag(mact & ~sout_oe_n & ~sck_oe_n & ~sinov, 1'b1);
    send(8'h5A, 1'b0);
    wait_sig(1);
    cmp_flag(rxc, 1'b0);
    // All four clock modes in both bit orders, random divisor and data
    for (k = 0; k < 8; k++) begin
      cfg(2'h3, 3'(k), 1'b1, 1'b1);
      set_div(2 + ($random(seed) & 3));
      clr_txc();
      send(8'($random(seed)), 1'b1);
      wait_sig(1);
      cmp_flag(sck, pol);
      cmp_flag(sout, 1'b1);
      rd();
    end
    // Two queued bytes: completion only after the second
    clr_txc();
    fmark = frames + 1;
    send(8'h81, 1'b1);
    send(8'h7E, 1'b1);
    wait_sig(3);
    cmp_flag(txc, 1'b0);
    wait_sig(1);
    rd();
    rd();
    // Three frames unread: the newest is lost
    clr_txc();
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b0);
    wait_sig(1);
    rd();
    rd();
    @(negedge clk);
    cmp_flag(rxc, 1'b0);
    // Writes outside the mode or with the transmitter off are dropped
    for (k = 0; k < 2; k++) begin
      cfg(k ? 2'h3 : 2'h1, 3'h0, 1'(k == 0), 1'b1);
      fmark = frames;
      poke(8'hC3);
      repeat (40) @(posedge clk);
      @(negedge clk);
      cmp_flag(tbe & (mact === 1'(k)), 1'b1);
      cmp_byte(8'(frames), 8'(fmark));
    end
    // Disable in mid-frame waits until the frame is out
    cfg(2'h3, 3'h0, 1'b1, 1'b1);
    clr_txc();
    send(8'hE7, 1'b1);
    txen <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_flag(sout_oe_n, 1'b0);
    wait_sig(1);
    repeat (3) @(negedge clk);
    cmp_flag(sout_oe_n, 1'b1);
    rd();
    repeat (3) @(negedge clk);
    cmp_byte(8'(exp_tx.size() + exp_rx.size()), 8'h00);
    report_and_stop();
  end
endmodule // usart_master_spi_mode_test
